// ### design/timer_cc_pkg.sv
// Package for the timer with capture/compare unit: register map, fields, modes.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package timer_cc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_COUNT_LOW  = 8'h04;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h08;
    localparam logic [7:0] OFS_CAP_LOW    = 8'h0C;
    localparam logic [7:0] OFS_CAP_HIGH   = 8'h10;
    localparam logic [7:0] OFS_CC_CONTROL = 8'h14;
    localparam logic [7:0] OFS_CC_SOURCE  = 8'h18;
    localparam logic [7:0] OFS_IRQ_REQ    = 8'h1C;
    localparam logic [7:0] OFS_IRQ_EN     = 8'h20;
    localparam logic [7:0] OFS_CLK_SEL    = 8'h24;
    localparam logic [7:0] OFS_OSC_EN     = 8'h28;
    localparam logic [7:0] OFS_IRQ_CTRL   = 8'h2C;
    localparam logic [7:0] OFS_STATUS     = 8'h30;

    // Counter control fields
    localparam int unsigned CTL_ON    = 0;
    localparam int unsigned CTL_ASYNC = 2;
    // Capture/compare control fields
    localparam int unsigned CCC_MODE_LSB = 0;
    localparam int unsigned CCC_EN       = 7;
    // Irq request / enable bit positions
    localparam int unsigned IRQ_OVF = 0;
    localparam int unsigned IRQ_CC  = 1;
    // Oscillator enable, global irq enable positions
    localparam int unsigned OSC_SEC = 3;
    localparam int unsigned GIE_BIT = 7;
    // Status bits
    localparam int unsigned ST_SLEEP = 0;
    localparam int unsigned ST_WAKE  = 1;
    localparam int unsigned ST_MATCH = 2;

    localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [3:0]  PRESC_4    = 4'h3;
    localparam logic [3:0]  PRESC_16   = 4'hF;

    typedef enum logic [3:0] {
        MODE_OFF       = 4'b0000,
        MODE_CMP_TOG   = 4'b0010,
        MODE_CAP_ANY   = 4'b0011,
        MODE_CAP_FALL  = 4'b0100,
        MODE_CAP_RISE  = 4'b0101,
        MODE_CAP_RISE4 = 4'b0110,
        MODE_CAP_RISE16= 4'b0111,
        MODE_CMP_SET   = 4'b1000,
        MODE_CMP_SPEC  = 4'b1011
    } cc_mode_t;

    typedef enum logic [1:0] {
        CLKSEL_INSTR = 2'b00,
        CLKSEL_SYS   = 2'b01,
        CLKSEL_EXT   = 2'b10,
        CLKSEL_SEC   = 2'b11
    } clk_sel_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_t;

    localparam logic [1:0] INSTR_DIV = 2'h3;
endpackage : timer_cc_pkg

// ### design/edge_source_sync.sv
// Source selector and two-flop synchroniser for the capture event inputs.
// Assumes src_in bits are asynchronous to clk and src_sel is synchronous; output is one synchronised level.
`timescale 1ns/1ns
module edge_source_sync #(
    parameter int unsigned NSRC = 8
) (
    input  wire logic            clk,      // System clock
    input  wire logic            rst_n,    // Async reset, active low
    input  wire logic [NSRC-1:0] src_in,   // Raw event sources, bit 0 is the pin
    input  wire logic [2:0]      src_sel,  // Source select
    output logic                 sync_out  // Selected, synchronised level
);
    logic [NSRC-1:0] meta;
    logic [NSRC-1:0] stable;
    logic            next_sync_out;

    always_comb begin
        next_sync_out = stable[src_sel];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= '0;
            stable   <= '0;
            sync_out <= 1'b0;
        end else begin
            meta     <= src_in;
            stable   <= meta;
            sync_out <= next_sync_out;
        end
    end
endmodule : edge_source_sync

// ### design/timer_capture_compare.sv
// Timer with 16-bit counter, overflow flag, sleep wake and capture/compare unit.
// Assumes a classic Wishbone master on clk; external clocks arrive as async levels.
`timescale 1ns/1ns
module timer_capture_compare
    import timer_cc_pkg::*;
#(
    parameter int unsigned NSRC = 8
) (
    input  wire logic            clk,        // System clock, 125 MHz
    input  wire logic            rst_n,      // Async reset, active low
    input  wire logic            wb_cyc_i,   // Wishbone cycle
    input  wire logic            wb_stb_i,   // Wishbone strobe
    input  wire logic            wb_we_i,    // Wishbone write enable
    input  wire logic [ADDR_W-1:0] wb_adr_i, // Byte address
    input  wire logic [3:0]      wb_sel_i,   // Byte selects
    input  wire logic [31:0]     wb_dat_i,   // Write data
    output logic [31:0]          wb_dat_o,   // Read data
    output logic                 wb_ack_o,   // Acknowledge
    input  wire logic            cap_pin_in, // Capture pin level
    input  wire logic            cap_pin_out,// Port latch driving pin
    input  wire logic            cap_pin_oe, // Pin driven as output
    input  wire logic [NSRC-1:1] event_src,  // Internal event sources
    input  wire logic            ext_clk,    // External clock input
    input  wire logic            sec_clk,    // Secondary oscillator clock
    input  wire logic            sleep,      // Core in sleep
    output logic                 irq,        // Interrupt request to core
    output logic                 wake,       // Wake-up request
    output logic                 cmp_event   // Compare match pulse
);
    logic [7:0]  counter_control, capture_compare_control, capture_source_register;
    logic [7:0]  counter_clock_select, oscillator_enables, irq_control_zero;
    logic [7:0]  irq_enable_register;
    logic [15:0] count, capture_val, compare_val;
    logic        overflow_flag, capture_compare_flag;
    logic [3:0]  presc;
    logic        cap_prev, ext_prev, sec_prev;
    logic [1:0]  ext_meta, sec_meta;
    logic [1:0]  div;
    logic        cap_sync;
    bus_state_t  bus_state;

    logic [7:0]  next_counter_control, next_cc_control, next_cc_source, next_clk_sel;
    logic [7:0]  next_osc_en, next_irq_ctrl, next_irq_en;
    logic [15:0] next_count, next_capture_val;
    logic        next_overflow_flag, next_cc_flag;
    logic [3:0]  next_presc;
    logic [1:0]  next_div;
    logic [31:0] next_dat;
    logic        next_ack, next_irq, next_wake, next_cmp_event;
    bus_state_t  next_bus_state;

    logic        wr, rd_ok, tick, cap_edge, cap_evt, match, spec_clr, count_wr;
    logic        mode_wr;
    logic [NSRC-1:0] src_vec;
    cc_mode_t    mode;

    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic s);
        merge8 = s ? d[7:0] : old;
    endfunction : merge8

    // pin level seen whether driven from port or from outside
    assign src_vec = {event_src, cap_pin_oe ? cap_pin_out : cap_pin_in};

    edge_source_sync #(.NSRC(NSRC)) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .src_in   (src_vec),
        .src_sel  (capture_source_register[2:0]),
        .sync_out (cap_sync)
    );

    assign mode     = cc_mode_t'(capture_compare_control[CCC_MODE_LSB +: 4]);
    assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && (bus_state == BUS_IDLE);
    assign count_wr = wr && wb_sel_i[0] && (wb_adr_i == OFS_COUNT_LOW || wb_adr_i == OFS_COUNT_HIGH);
    assign mode_wr  = wr && wb_sel_i[0] && (wb_adr_i == OFS_CC_CONTROL);

    // Count tick from selected source
    always_comb begin
        case (clk_sel_t'(counter_clock_select[1:0]))
            CLKSEL_INSTR: tick = (div == INSTR_DIV);
            CLKSEL_SYS:   tick = 1'b1;
            CLKSEL_EXT:   tick = ext_meta[1] && !ext_prev;
            default:      tick = sec_meta[1] && !sec_prev && oscillator_enables[OSC_SEC];
        endcase
        // in sleep only async external/secondary counting survives
        if (sleep && !(counter_control[CTL_ASYNC] &&
                       counter_clock_select[1])) begin
            tick = 1'b0;
        end
        if (!counter_control[CTL_ON]) begin
            tick = 1'b0;
        end
    end

    // Capture edge qualification
    always_comb begin
        cap_edge = 1'b0;
        cap_evt  = 1'b0;
        next_presc = presc;
        if (capture_compare_control[CCC_EN]) begin
            case (mode)
                MODE_CAP_FALL:  cap_evt = cap_prev && !cap_sync;
                MODE_CAP_RISE:  cap_evt = !cap_prev && cap_sync;
                MODE_CAP_ANY:   cap_evt = cap_prev != cap_sync;
                MODE_CAP_RISE4, MODE_CAP_RISE16: begin
                    cap_edge = !cap_prev && cap_sync;
                    if (cap_edge) begin
                        next_presc = presc + 4'h1;
                        cap_evt = (presc == ((mode == MODE_CAP_RISE4) ? PRESC_4 : PRESC_16));
                        if (cap_evt) next_presc = 4'h0;
                    end
                end
                default: cap_evt = 1'b0;
            endcase
        end
        if (mode_wr) begin
            next_presc = 4'h0;
        end
    end

    assign match    = capture_compare_control[CCC_EN] && mode[3] && (count == compare_val);
    assign spec_clr = match && (mode == MODE_CMP_SPEC) && tick;

    // Counter, flags, capture
    always_comb begin
        next_count         = count;
        next_overflow_flag = overflow_flag;
        next_cc_flag       = capture_compare_flag;
        next_capture_val   = capture_val;
        next_cmp_event     = match && tick;
        // Software writes first, so hardware sets below win
        if (wr && wb_sel_i[0] && wb_adr_i == OFS_IRQ_REQ) begin
            next_overflow_flag = wb_dat_i[IRQ_OVF];
            next_cc_flag       = wb_dat_i[IRQ_CC];
        end
        if (spec_clr) begin
            next_count = COUNT_ZERO;
        end else if (tick) begin
            next_count = count + 16'h0001;
            if (count == COUNT_MAX) begin
                next_overflow_flag = 1'b1;
            end
        end
        if (count_wr) begin
            if (wb_adr_i == OFS_COUNT_LOW) next_count[7:0] = wb_dat_i[7:0];
            else next_count[15:8] = wb_dat_i[7:0];
        end
        if (cap_evt) begin
            next_capture_val = count;
            next_cc_flag     = 1'b1;
        end
        // Bus write to the value register wins over a capture
        if (wr && wb_sel_i[0]) begin
            if (wb_adr_i == OFS_CAP_LOW) begin
                next_capture_val[7:0] = wb_dat_i[7:0];
            end else if (wb_adr_i == OFS_CAP_HIGH) begin
                next_capture_val[15:8] = wb_dat_i[7:0];
            end
        end
        if (match && tick && mode[3]) begin
            next_cc_flag = 1'b1;
        end
        next_div = (sleep) ? div : div + 2'h1;
        next_irq  = irq_control_zero[GIE_BIT] && counter_control[CTL_ON] &&
                    ((next_overflow_flag && irq_enable_register[IRQ_OVF]) ||
                     (next_cc_flag && irq_enable_register[IRQ_CC]));
        next_wake = sleep && next_overflow_flag && irq_enable_register[IRQ_OVF] &&
                    counter_control[CTL_ON];
    end

    // Register bus
    always_comb begin
        next_counter_control = counter_control;
        next_cc_control      = capture_compare_control;
        next_cc_source       = capture_source_register;
        next_clk_sel         = counter_clock_select;
        next_osc_en          = oscillator_enables;
        next_irq_ctrl        = irq_control_zero;
        next_irq_en          = irq_enable_register;
        next_bus_state       = BUS_IDLE;
        next_ack             = 1'b0;
        next_dat             = wb_dat_o;
        rd_ok                = wb_cyc_i && wb_stb_i && (bus_state == BUS_IDLE);
        if (rd_ok) begin
            next_bus_state = BUS_ACK;
            next_ack       = 1'b1;
            next_dat       = 32'h0000_0000;
            if (wb_adr_i == OFS_CONTROL) next_dat[7:0] = counter_control;
            else if (wb_adr_i == OFS_COUNT_LOW)  next_dat[7:0] = count[7:0];
            else if (wb_adr_i == OFS_COUNT_HIGH) next_dat[7:0] = count[15:8];
            else if (wb_adr_i == OFS_CAP_LOW)    next_dat[7:0] = capture_val[7:0];
            else if (wb_adr_i == OFS_CAP_HIGH)   next_dat[7:0] = capture_val[15:8];
            else if (wb_adr_i == OFS_CC_CONTROL) next_dat[7:0] = capture_compare_control;
            else if (wb_adr_i == OFS_CC_SOURCE)  next_dat[7:0] = capture_source_register;
            else if (wb_adr_i == OFS_IRQ_REQ)    next_dat[1:0] = {capture_compare_flag, overflow_flag};
            else if (wb_adr_i == OFS_IRQ_EN)     next_dat[7:0] = irq_enable_register;
            else if (wb_adr_i == OFS_CLK_SEL)    next_dat[7:0] = counter_clock_select;
            else if (wb_adr_i == OFS_OSC_EN)     next_dat[7:0] = oscillator_enables;
            else if (wb_adr_i == OFS_IRQ_CTRL)   next_dat[7:0] = irq_control_zero;
            else if (wb_adr_i == OFS_STATUS)     next_dat[2:0] = {match, wake, sleep};
        end
        if (wr) begin
            if (wb_adr_i == OFS_CONTROL)
                next_counter_control = merge8(counter_control, wb_dat_i, wb_sel_i[0]);
            else if (wb_adr_i == OFS_CC_CONTROL)
                next_cc_control = merge8(capture_compare_control, wb_dat_i, wb_sel_i[0]);
            else if (wb_adr_i == OFS_CC_SOURCE)
                next_cc_source = merge8(capture_source_register, wb_dat_i, wb_sel_i[0]);
            else if (wb_adr_i == OFS_IRQ_EN)
                next_irq_en = merge8(irq_enable_register, wb_dat_i, wb_sel_i[0]);
            else if (wb_adr_i == OFS_CLK_SEL)
                next_clk_sel = merge8(counter_clock_select, wb_dat_i, wb_sel_i[0]);
            else if (wb_adr_i == OFS_OSC_EN)
                next_osc_en = merge8(oscillator_enables, wb_dat_i, wb_sel_i[0]);
            else if (wb_adr_i == OFS_IRQ_CTRL)
                next_irq_ctrl = merge8(irq_control_zero, wb_dat_i, wb_sel_i[0]);
        end
    end

    // Compare value shares the capture register pair
    assign compare_val = capture_val;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_control         <= 8'h00;
            capture_compare_control <= 8'h00;
            capture_source_register <= 8'h00;
            counter_clock_select    <= 8'h00;
            oscillator_enables      <= 8'h00;
            irq_control_zero        <= 8'h00;
            irq_enable_register     <= 8'h00;
            count                   <= COUNT_ZERO;
            capture_val             <= COUNT_ZERO;
            overflow_flag           <= 1'b0;
            capture_compare_flag    <= 1'b0;
            presc                   <= 4'h0;
            cap_prev                <= 1'b0;
            ext_meta                <= 2'b00;
            sec_meta                <= 2'b00;
            ext_prev                <= 1'b0;
            sec_prev                <= 1'b0;
            div                     <= 2'h0;
            bus_state               <= BUS_IDLE;
            wb_ack_o                <= 1'b0;
            wb_dat_o                <= 32'h0000_0000;
            irq                     <= 1'b0;
            wake                    <= 1'b0;
            cmp_event               <= 1'b0;
        end else begin
            counter_control         <= next_counter_control;
            capture_compare_control <= next_cc_control;
            capture_source_register <= next_cc_source;
            counter_clock_select    <= next_clk_sel;
            oscillator_enables      <= next_osc_en;
            irq_control_zero        <= next_irq_ctrl;
            irq_enable_register     <= next_irq_en;
            count                   <= next_count;
            capture_val             <= next_capture_val;
            overflow_flag           <= next_overflow_flag;
            capture_compare_flag    <= next_cc_flag;
            presc                   <= next_presc;
            cap_prev                <= cap_sync;
            ext_meta                <= {ext_meta[0], ext_clk};
            sec_meta                <= {sec_meta[0], sec_clk};
            ext_prev                <= ext_meta[1];
            sec_prev                <= sec_meta[1];
            div                     <= next_div;
            bus_state               <= next_bus_state;
            wb_ack_o                <= next_ack;
            wb_dat_o                <= next_dat;
            irq                     <= next_irq;
            wake                    <= next_wake;
            cmp_event               <= next_cmp_event;
        end
    end
endmodule : timer_capture_compare

// ### sim/cap_source_model.sv
// Partner model: capture pin and internal event source levels.
// Assumes bursts are requested on clk edges by the bench.
`timescale 1ns/1ns
module cap_source_model (
    input  wire logic       clk,    // Bench clock
    input  wire logic       go,     // Start a burst
    input  wire logic [2:0] sel,    // Line to toggle, 0 is the pin
    input  wire logic [5:0] n,      // Toggles in the burst
    output logic            pin,    // Capture pin level
    output logic [7:1]      events, // Internal event levels
    output logic            busy    // Burst in progress
);
    logic [5:0] left;
    logic [2:0] ph;
    initial begin
        pin = 1'b0;
        events = 7'h00;
        busy = 1'b0;
        left = 6'h00;
        ph = 3'h0;
    end
    // One toggle each 8 cycles, slow enough for the synchroniser
    always @(posedge clk) begin
        if (go && !busy) begin
            left <= n;
            busy <= (n != 6'h00);
            ph   <= 3'h0;
        end else if (busy) begin
            ph <= ph + 3'h1;
            if (ph == 3'h7) begin
                left <= left - 6'h01;
                busy <= (left != 6'h01);
                if (sel == 3'h0) pin <= ~pin;
                else events[sel] <= ~events[sel];
            end
        end
    end
endmodule : cap_source_model

// ### sim/timer_capture_compare_checker.sv
// Checker for timer_capture_compare: bus handshake, read data, wake and match.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module timer_capture_compare_checker
    import timer_cc_pkg::*;
#(
    parameter int unsigned NSRC = 8
) (
    input wire logic              clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, // Bus control
    input wire logic [ADDR_W-1:0] wb_adr_i,   // Address
    input wire logic [3:0]        wb_sel_i,   // Byte selects
    input wire logic [31:0]       wb_dat_i,   // Write data
    input wire logic [31:0]       wb_dat_o,   // Read data
    input wire logic              wb_ack_o, cap_pin_in, cap_pin_out, cap_pin_oe, // Ack and pin
    input wire logic [NSRC-1:1]   event_src,  // Event sources
    input wire logic              ext_clk, sec_clk, sleep, irq, wake, cmp_event // Misc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ack_follows; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("ack missing");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_unmapped_zero; wb_ack_o && !wb_we_i && wb_adr_i > OFS_STATUS |-> wb_dat_o == 32'h0; endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    property p_byte_wide; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000; endproperty
    a_byte_wide: assert property (p_byte_wide) else $error("upper read bits set");
    property p_wake_sleep; wake |-> $past(sleep); endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake outside sleep");
    property p_status; wb_ack_o && !wb_we_i && wb_adr_i == OFS_STATUS |->
        wb_dat_o[ST_WAKE] == $past(wake) && wb_dat_o[ST_SLEEP] == $past(sleep); endproperty
    a_status: assert property (p_status) else $error("status mismatch");
    property p_cmp_pulse; cmp_event |=> !cmp_event; endproperty
    a_cmp_pulse: assert property (p_cmp_pulse) else $error("match pulse too long");
endmodule : timer_capture_compare_checker
bind timer_capture_compare timer_capture_compare_checker #(.NSRC(NSRC)) chk_u (.clk(clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cap_pin_in(cap_pin_in),
    .cap_pin_out(cap_pin_out), .cap_pin_oe(cap_pin_oe), .event_src(event_src), .ext_clk(ext_clk),
    .sec_clk(sec_clk), .sleep(sleep), .irq(irq), .wake(wake), .cmp_event(cmp_event));

// ### sim/timer_capture_compare_tb.sv
// Testbench for timer_capture_compare: Wishbone tasks and one task per scenario.
// Assumes cap_source_model drives the pin and event sources.
`timescale 1ns/1ns
module timer_capture_compare_tb;
    import timer_cc_pkg::*;
    localparam logic [3:0] CAP_MD [5] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16, MODE_CAP_ANY};
    localparam logic [5:0] CAP_PRE [5] = '{6'h01, 6'h00, 6'h06, 6'h1E, 6'h00};
    logic        clk = 1'b0, rst_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, sec_run = 1'b0;
    logic        pin_out = 1'b0, pin_oe = 1'b0, sec_clk = 1'b0, sleep = 1'b0, go = 1'b0;
    logic        pin, busy, wb_ack, irq, wake, cmp;
    logic [2:0]  src = 3'h0, sec_div = 3'h0;
    logic [5:0]  n_tog = 6'h00;
    logic [7:0]  wb_adr = 8'h00, rdat;
    logic [31:0] wb_dat = 32'h0, wb_q;
    logic [7:1]  events;
    int          n_fail = 0, tests_run = 0, k;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        sec_div <= sec_div + 3'h1;
        sec_clk <= sec_run & sec_div[2];
    end
    cap_source_model src_u (.clk(clk), .go(go), .sel(src), .n(n_tog), .pin(pin), .events(events), .busy(busy));
    timer_capture_compare dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
        .cap_pin_in(pin), .cap_pin_out(pin_out), .cap_pin_oe(pin_oe), .event_src(events), .ext_clk(1'b0),
        .sec_clk(sec_clk), .sleep(sleep), .irq(irq), .wake(wake), .cmp_event(cmp));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= {24'h000000, d};
        @(posedge clk);
        while (wb_ack !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        chk("ack", 8'h01, {7'h00, wb_ack});
        rdat = wb_q[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : bus
    task automatic burst(input logic [2:0] s, input logic [5:0] n);
        @(posedge clk);
        src   <= s;
        n_tog <= n;
        go    <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        for (k = 0; k < 600 && busy === 1'b1; k++) @(negedge clk);
        repeat (8) @(negedge clk);
    endtask : burst
    task automatic t_modes();
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, OFS_CC_CONTROL, {4'h8, CAP_MD[i]});
            bus(1'b1, OFS_COUNT_LOW, 8'h40 + 8'(i));
            bus(1'b1, OFS_COUNT_HIGH, 8'hA5);
            bus(1'b1, OFS_IRQ_REQ, 8'h00);
            burst(3'h0, CAP_PRE[i]);
            bus(1'b0, OFS_IRQ_REQ, 8'h00);
            chk("early capture", 8'h00, rdat & 8'h02);
            burst(3'h0, 6'h01);
            bus(1'b0, OFS_IRQ_REQ, 8'h00);
            chk("capture flag", 8'h02, rdat & 8'h02);
            bus(1'b0, OFS_CAP_LOW, 8'h00);
            chk("capture low", 8'h40 + 8'(i), rdat);
            bus(1'b0, OFS_CAP_HIGH, 8'h00);
            chk("capture high", 8'hA5, rdat);
            if (CAP_PRE[i][0] == 1'b0) burst(3'h0, 6'h01);
        end
        $display("modes done");
    endtask : t_modes
    task automatic t_sources();
        bus(1'b1, OFS_CC_CONTROL, {4'h8, MODE_CAP_RISE});
        bus(1'b1, OFS_CC_SOURCE, 8'h03);
        bus(1'b1, OFS_COUNT_LOW, 8'h21);
        bus(1'b1, OFS_IRQ_REQ, 8'h00);
        burst(3'h0, 6'h02);
        bus(1'b0, OFS_IRQ_REQ, 8'h00);
        chk("pin ignored", 8'h00, rdat & 8'h02);
        burst(3'h3, 6'h02);
        bus(1'b0, OFS_IRQ_REQ, 8'h00);
        chk("source capture", 8'h02, rdat & 8'h02);
        bus(1'b1, OFS_CC_SOURCE, 8'h00);
        bus(1'b1, OFS_COUNT_LOW, 8'h32);
        pin_oe  <= 1'b1;
        pin_out <= 1'b1;
        repeat (8) @(posedge clk);
        pin_out <= 1'b0;
        pin_oe  <= 1'b0;
        bus(1'b0, OFS_CAP_LOW, 8'h00);
        chk("port write capture", 8'h32, rdat);
        bus(1'b1, OFS_CC_CONTROL, 8'h00);
        $display("sources done");
    endtask : t_sources
    task automatic t_overflow();
        bus(1'b1, OFS_COUNT_LOW, 8'hFE);
        bus(1'b1, OFS_COUNT_HIGH, 8'hFF);
        bus(1'b1, OFS_IRQ_REQ, 8'h00);
        bus(1'b1, OFS_IRQ_EN, 8'h01);
        bus(1'b1, OFS_IRQ_CTRL, 8'h80);
        bus(1'b1, OFS_CONTROL, 8'h01);
        for (k = 0; k < 100 && irq !== 1'b1; k++) @(negedge clk);
        chk("irq", 8'h01, {7'h00, irq});
        bus(1'b0, OFS_COUNT_HIGH, 8'h00);
        chk("wrapped high", 8'h00, rdat);
        bus(1'b0, 8'h40, 8'h00);
        chk("unmapped read", 8'h00, rdat);
        bus(1'b1, OFS_IRQ_CTRL, 8'h00);
        repeat (3) @(negedge clk);
        chk("irq masked", 8'h00, {7'h00, irq});
        bus(1'b0, OFS_IRQ_REQ, 8'h00);
        chk("overflow flag", 8'h01, rdat & 8'h01);
        bus(1'b1, OFS_CONTROL, 8'h00);
        $display("overflow done");
    endtask : t_overflow
    task automatic t_compare();
        bus(1'b1, OFS_COUNT_LOW, 8'h00);
        bus(1'b1, OFS_COUNT_HIGH, 8'h00);
        bus(1'b1, OFS_IRQ_REQ, 8'h00);
        bus(1'b1, OFS_CAP_LOW, 8'h10);
        bus(1'b1, OFS_CAP_HIGH, 8'h00);
        bus(1'b1, OFS_CC_CONTROL, {4'h8, MODE_CMP_SPEC});
        bus(1'b1, OFS_CONTROL, 8'h01);
        for (k = 0; k < 400 && cmp !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        for (k = 1; k < 400 && cmp !== 1'b1; k++) @(negedge clk);
        chk("period", 8'(17 * (int'(INSTR_DIV) + 1)), 8'(k));
        bus(1'b0, OFS_IRQ_REQ, 8'h00);
        chk("no overflow", 8'h00, rdat & 8'h01);
        bus(1'b0, OFS_COUNT_HIGH, 8'h00);
        chk("cleared high", 8'h00, rdat);
        bus(1'b1, OFS_CONTROL, 8'h00);
        bus(1'b1, OFS_CC_CONTROL, {4'h8, MODE_CMP_SET});
        bus(1'b1, OFS_COUNT_LOW, 8'h08);
        bus(1'b1, OFS_CONTROL, 8'h01);
        for (k = 0; k < 100 && cmp !== 1'b1; k++) @(negedge clk);
        chk("plain match", 8'h01, {7'h00, cmp});
        bus(1'b0, OFS_COUNT_LOW, 8'h00);
        chk("no clear", 8'h01, {7'h00, rdat > 8'h10});
        bus(1'b1, OFS_CONTROL, 8'h00);
        bus(1'b1, OFS_CC_CONTROL, 8'h00);
        $display("compare done");
    endtask : t_compare
    task automatic t_sleep();
        logic [7:0] first;
        bus(1'b1, OFS_COUNT_LOW, 8'hF0);
        bus(1'b1, OFS_COUNT_HIGH, 8'hFF);
        bus(1'b1, OFS_IRQ_REQ, 8'h00);
        bus(1'b1, OFS_CLK_SEL, 8'h03);
        bus(1'b1, OFS_OSC_EN, 8'h08);
        bus(1'b1, OFS_IRQ_CTRL, 8'h80);
        bus(1'b1, OFS_CONTROL, 8'h05);
        sleep   <= 1'b1;
        sec_run <= 1'b1;
        for (k = 0; k < 600 && wake !== 1'b1; k++) @(negedge clk);
        chk("wake", 8'h01, {7'h00, wake});
        chk("irq in sleep", 8'h01, {7'h00, irq});
        bus(1'b0, OFS_STATUS, 8'h00);
        chk("status", 8'h03, rdat & 8'h03);
        bus(1'b1, OFS_CONTROL, 8'h01);
        bus(1'b1, OFS_CLK_SEL, 8'h00);
        bus(1'b0, OFS_COUNT_LOW, 8'h00);
        first = rdat;
        repeat (20) @(negedge clk);
        bus(1'b0, OFS_COUNT_LOW, 8'h00);
        chk("halt in sleep", first, rdat);
        sleep   <= 1'b0;
        sec_run <= 1'b0;
        $display("sleep done");
    endtask : t_sleep
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_modes();
        t_sources();
        t_overflow();
        t_compare();
        t_sleep();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end
endmodule : timer_capture_compare_tb
